// ==== core/amr_core.sv ====
/*
  Address map decoder and program counter sequencer for a small 8-bit
  core. Holds the 16-bit program counter, the reset and interrupt vector
  fetch, the table-call entry fetch, and region decode of data accesses.
  Assumes the flash answers a byte read in the same cycle as the request, that
  the reset pin reaches NRST_I already synchronised to CLK_I, and that the
  core's decode stage supplies pc step, branch and table-call requests.
*/
`timescale 1ns/100ps

// Overview of operation
// RULE_01 - One flat 64 KB space, 16-bit address.
// RULE_02 - Bytes 0000H to 0013H hold vector entries.
// RULE_03 - Vector low byte even, high byte odd.
// RULE_04 - Reset and interrupts branch via fixed slots.
// RULE_05 - Table call reads entry from 0040H-007FH.
// RULE_06 - Option byte lives at 0080H.
// RULE_07 - Protection byte lives at 0081H.
// RULE_08 - 128-byte fast RAM at FE80H-FEFFH, stack.
// RULE_09 - Peripheral registers decode at FF00H-FFFFH.
// RULE_10 - Flash is 1K, 2K or 4K from zero.
// RULE_11 - Program counter is a 16-bit register.
// RULE_12 - Sequential fetch advances by instruction length.
// RULE_13 - Branch loads immediate or register value.
// RULE_14 - After reset, PC loads from 0000H/0001H.
// RULE_15 - Reset input is active low.
// RULE_16 - RAM and registers have short addressing modes.
// RULE_17 - Unmapped reads undefined, writes ignored.
// RULE_18 - Vector fetch starts first edge after reset.
module amr_core
  import amr_pkg::*;
#(
  parameter int FLASH_BYTES = AMR_FLASH_4K
)
(
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  // Program control requests from the decode stage.
  input  wire logic [1:0]  PC_OP_I,
  input  wire logic [1:0]  PC_LEN_I,
  input  wire logic [15:0] PC_TARGET_I,
  input  wire logic        TCALL_REQ_I,
  input  wire logic [4:0]  TCALL_IDX_I,
  input  wire logic        IRQ_REQ_I,
  input  wire logic [2:0]  IRQ_SRC_I,
  // Data access requests from the execute stage.
  input  wire logic        DACC_REQ_I,
  input  wire logic        DACC_WR_I,
  input  wire logic [1:0]  DACC_MODE_I,
  input  wire logic [15:0] DACC_ADDR_I,
  input  wire logic [7:0]  DACC_WDATA_I,
  // Flash byte read port.
  input  wire logic [7:0]  FLASH_RDATA_I,
  output logic      [15:0] FLASH_ADDR_O,
  output logic             FLASH_RD_O,
  // Decoded data access towards RAM and registers.
  input  wire logic [7:0]  MEM_RDATA_I,
  output logic      [15:0] MEM_ADDR_O,
  output logic      [2:0]  MEM_REGION_O,
  output logic             MEM_RD_O,
  output logic             MEM_WR_O,
  output logic      [7:0]  MEM_WDATA_O,
  output logic      [7:0]  DACC_RDATA_O,
  // Program counter and sequencer status.
  output logic      [15:0] PC_O,
  output logic             RUN_O,
  output logic             VEC_LOADED_O
);

  // Only the three flash sizes are served by the decoder.
  initial
  begin
    if (FLASH_BYTES != AMR_FLASH_1K && FLASH_BYTES != AMR_FLASH_2K &&
        FLASH_BYTES != AMR_FLASH_4K)
    begin
      $error("FLASH_BYTES must be 1024, 2048 or 4096.");
    end
  end

  // Top of implemented flash, used for bounds on every data access.
  localparam logic [15:0] FLASH_TOP = 16'(FLASH_BYTES - 1);

  amr_state_t  state_q;        // Sequencer state.
  logic [15:0] pc_q;           // Address of the next fetch.
  logic [7:0]  lo_byte_q;      // Low half of a vector or table entry.
  logic [15:0] vec_addr_q;     // Even address of the entry being read.
  logic        run_q;          // Normal fetching enabled.
  logic        vec_loaded_q;   // Reset vector has been taken.
  logic [15:0] flash_addr_q;   // Registered flash address.
  logic        flash_rd_q;     // Registered flash read strobe.
  logic [15:0] irq_slot;       // Vector slot for the pending source.
  logic [15:0] tcall_slot;     // Table entry address for a table call.
  logic [15:0] daddr;          // Full address after short-mode widening.
  amr_region_t dregion;        // Region of the data access.

  // Vector slot lookup; reset uses slot zero, source code 0 maps to reset.
  always_comb
  begin
    case (IRQ_SRC_I)
      3'h1:    irq_slot = AMR_VEC_LOWV;   // RULE_04
      3'h2:    irq_slot = AMR_VEC_EXT0;
      3'h3:    irq_slot = AMR_VEC_EXT1;
      3'h4:    irq_slot = AMR_VEC_TMH1;
      3'h5:    irq_slot = AMR_VEC_TMM0;
      3'h6:    irq_slot = AMR_VEC_TMM1;
      3'h7:    irq_slot = AMR_VEC_ADC;
      default: irq_slot = AMR_VEC_RESET;
    endcase
  end

  // Each table entry is two bytes, so 32 entries fill 64 bytes.
  assign tcall_slot = AMR_TCALL_LO + {10'h000, TCALL_IDX_I, 1'b0}; // RULE_05

  // Short modes carry an 8-bit offset that is widened to a full address.
  always_comb
  begin
    case (DACC_MODE_I)
      AMR_AM_SADDR: daddr = AMR_RAM_SHORT | {8'h00, DACC_ADDR_I[7:0]};
      AMR_AM_SFR:   daddr = AMR_SFR_SHORT | {8'h00, DACC_ADDR_I[7:0]};
      default:      daddr = DACC_ADDR_I;  // RULE_16
    endcase
  end

  // Region decode over the flat space; byte 0080H and 0081H are
  // separated from the flash region for data accesses; instruction fetch does not check them.
  always_comb
  begin
    if (daddr == AMR_OPT_ADDR)
      dregion = AMR_REG_OPT;              // RULE_06
    else if (daddr == AMR_PROT_ADDR)
      dregion = AMR_REG_PROT;             // RULE_07
    else if (daddr <= FLASH_TOP)
      dregion = AMR_REG_FLASH;            // RULE_10
    else if (daddr >= AMR_RAM_LO && daddr <= AMR_RAM_HI)
      dregion = AMR_REG_RAM;              // RULE_08
    else if (daddr >= AMR_SFR_LO)
      dregion = AMR_REG_SFR;              // RULE_09
    else
      dregion = AMR_REG_NONE;             // RULE_01
  end

  // Sequencer: vector fetch, table-call fetch and run.
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)                          // RULE_15
    begin
      state_q      <= AMR_ST_RESET;
      vec_addr_q   <= AMR_VEC_RESET;
      lo_byte_q    <= 8'h00;
      run_q        <= 1'b0;
      vec_loaded_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        // First edge after release: request the low byte.
        AMR_ST_RESET:
        begin
          state_q    <= AMR_ST_VLO;       // RULE_18
          vec_addr_q <= AMR_VEC_RESET;    // RULE_14
        end
        // Low byte arrives from the even address.
        AMR_ST_VLO, AMR_ST_IVLO, AMR_ST_TLO:
        begin
          lo_byte_q <= FLASH_RDATA_I;     // RULE_03
          if (state_q == AMR_ST_VLO)
            state_q <= AMR_ST_VHI;
          else if (state_q == AMR_ST_IVLO)
            state_q <= AMR_ST_IVHI;
          else
            state_q <= AMR_ST_THI;
        end
        // High byte arrives; target is complete.
        AMR_ST_VHI, AMR_ST_IVHI, AMR_ST_THI:
        begin
          state_q <= AMR_ST_RUN;
          run_q   <= 1'b1;
          if (state_q == AMR_ST_VHI)
            vec_loaded_q <= 1'b1;
        end
        // Normal fetching; interrupts win over table calls.
        AMR_ST_RUN:
        begin
          if (IRQ_REQ_I)
          begin
            state_q    <= AMR_ST_IVLO;    // RULE_04
            vec_addr_q <= irq_slot;
            run_q      <= 1'b0;
          end
          else if (TCALL_REQ_I)
          begin
            state_q    <= AMR_ST_TLO;     // RULE_05
            vec_addr_q <= tcall_slot;
            run_q      <= 1'b0;
          end
        end
        default:
        begin
          state_q <= AMR_ST_RESET;
        end
      endcase
    end
  end

  // Program counter updates.
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      pc_q <= AMR_VEC_RESET;              // RULE_11
    end
    else
    begin
      case (state_q)
        AMR_ST_VHI, AMR_ST_IVHI, AMR_ST_THI:
          pc_q <= {FLASH_RDATA_I, lo_byte_q};   // RULE_14
        AMR_ST_RUN:
        begin
          if (!IRQ_REQ_I && !TCALL_REQ_I)
          begin
            case (PC_OP_I)
              AMR_PC_SEQ:
                pc_q <= pc_q + {14'h0000, PC_LEN_I};  // RULE_12
              AMR_PC_IMM, AMR_PC_REG:
                pc_q <= PC_TARGET_I;                  // RULE_13
              default:
                pc_q <= pc_q;
            endcase
          end
        end
        default:
          pc_q <= pc_q;
      endcase
    end
  end

  // Flash read port: vector bytes while fetching entries, else the PC.
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      flash_addr_q <= AMR_VEC_RESET;
      flash_rd_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        AMR_ST_RESET:
        begin
          flash_addr_q <= AMR_VEC_RESET;        // RULE_18
          flash_rd_q   <= 1'b1;
        end
        AMR_ST_VLO, AMR_ST_IVLO, AMR_ST_TLO:
        begin
          flash_addr_q <= vec_addr_q | 16'h0001; // RULE_03
          flash_rd_q   <= 1'b1;
        end
        AMR_ST_RUN:
        begin
          flash_addr_q <= (IRQ_REQ_I) ? irq_slot :
                          (TCALL_REQ_I) ? tcall_slot : pc_q;
          flash_rd_q   <= 1'b1;
        end
        default:
        begin
          flash_addr_q <= pc_q;
          flash_rd_q   <= 1'b0;
        end
      endcase
    end
  end

  // Data access path; unmapped space neither reads nor writes.
  always_ff @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      MEM_ADDR_O   <= 16'h0000;
      MEM_REGION_O <= AMR_REG_NONE;
      MEM_RD_O     <= 1'b0;
      MEM_WR_O     <= 1'b0;
      MEM_WDATA_O  <= 8'h00;
      DACC_RDATA_O <= 8'h00;
    end
    else
    begin
      MEM_ADDR_O   <= daddr;
      MEM_REGION_O <= dregion;
      MEM_WDATA_O  <= DACC_WDATA_I;
      MEM_RD_O     <= DACC_REQ_I && !DACC_WR_I && dregion != AMR_REG_NONE;
      MEM_WR_O     <= DACC_REQ_I && DACC_WR_I && dregion != AMR_REG_NONE;
      DACC_RDATA_O <= (MEM_REGION_O == AMR_REG_NONE) ?
                      AMR_UNMAPPED_DATA : MEM_RDATA_I;  // RULE_17
    end
  end

  assign FLASH_ADDR_O = flash_addr_q;
  assign FLASH_RD_O   = flash_rd_q;
  assign PC_O         = pc_q;
  assign RUN_O        = run_q;
  assign VEC_LOADED_O = vec_loaded_q;

  // The PC takes the assembled vector on the edge that ends the high read.
  property p_vec_load;
    @(posedge CLK_I) disable iff (!NRST_I)
    state_q == AMR_ST_VHI |=> pc_q == {$past(FLASH_RDATA_I), $past(lo_byte_q)};
  endproperty
  a_vec_load: assert property (p_vec_load) // RULE_14
    else $error("PC not loaded from reset vector.");

  // Vector fetch reaches run state three edges after reset release.
  property p_start;
    @(posedge CLK_I) disable iff (!NRST_I)
    $rose(NRST_I) ##0 state_q == AMR_ST_RESET |-> ##3 run_q;
  endproperty
  a_start: assert property (p_start) // RULE_18
    else $error("Reset vector fetch timing wrong.");

  // Sequential step adds the instruction length.
  property p_seq;
    @(posedge CLK_I) disable iff (!NRST_I)
    state_q == AMR_ST_RUN && !IRQ_REQ_I && !TCALL_REQ_I &&
    PC_OP_I == AMR_PC_SEQ |=> pc_q == $past(pc_q) + $past(PC_LEN_I);
  endproperty
  a_seq: assert property (p_seq) // RULE_12
    else $error("PC step wrong.");

  // Branch loads the supplied target.
  property p_branch;
    @(posedge CLK_I) disable iff (!NRST_I)
    state_q == AMR_ST_RUN && !IRQ_REQ_I && !TCALL_REQ_I &&
    PC_OP_I[1] |=> pc_q == $past(PC_TARGET_I);
  endproperty
  a_branch: assert property (p_branch) // RULE_13
    else $error("Branch target not loaded.");

  // Interrupt fetch reads the even slot then the odd byte.
  property p_irq_slot;
    @(posedge CLK_I) disable iff (!NRST_I)
    state_q == AMR_ST_RUN && IRQ_REQ_I |=>
    FLASH_ADDR_O <= AMR_VEC_HI && !FLASH_ADDR_O[0] // RULE_02
    ##1 FLASH_ADDR_O[0];
  endproperty
  a_irq_slot: assert property (p_irq_slot) // RULE_04
    else $error("Interrupt vector address wrong.");

  // Table call reads inside the table area.
  property p_tcall;
    @(posedge CLK_I) disable iff (!NRST_I)
    state_q == AMR_ST_RUN && !IRQ_REQ_I && TCALL_REQ_I |=>
    FLASH_ADDR_O >= AMR_TCALL_LO && FLASH_ADDR_O <= AMR_TCALL_HI;
  endproperty
  a_tcall: assert property (p_tcall) // RULE_05
    else $error("Table call address out of table.");

  // Unmapped space never strobes memory.
  property p_unmapped;
    @(posedge CLK_I) disable iff (!NRST_I)
    MEM_REGION_O == AMR_REG_NONE |-> !MEM_RD_O && !MEM_WR_O;
  endproperty
  a_unmapped: assert property (p_unmapped) // RULE_17
    else $error("Strobe into unmapped space.");

  // Short RAM mode lands inside the RAM window when offset is high.
  property p_short;
    @(posedge CLK_I) disable iff (!NRST_I)
    DACC_REQ_I && DACC_MODE_I == AMR_AM_SADDR && DACC_ADDR_I[7] |=>
    MEM_REGION_O == AMR_REG_RAM;
  endproperty
  a_short: assert property (p_short) // RULE_16
    else $error("Short RAM access misdecoded.");

endmodule

// ==== core/amr_pkg.sv ====
/*
  Constants for the address map decoder and program counter sequencer:
  region bounds, vector slots, table-call area and timing counts.
  Assumes a single clock domain and a 16-bit byte address space.
*/
package amr_pkg;

  // Address width of the flat space, 64 KB in all.
  localparam int AMR_ADDR_W = 16;

  // Vector table area, twenty bytes of branch targets.
  localparam logic [15:0] AMR_VEC_LO       = 16'h0000;
  localparam logic [15:0] AMR_VEC_HI       = 16'h0013;
  // Vector slot addresses, one per source.
  localparam logic [15:0] AMR_VEC_RESET    = 16'h0000;
  localparam logic [15:0] AMR_VEC_LOWV     = 16'h0006;
  localparam logic [15:0] AMR_VEC_EXT0     = 16'h0008;
  localparam logic [15:0] AMR_VEC_EXT1     = 16'h000A;
  localparam logic [15:0] AMR_VEC_TMH1     = 16'h000C;
  localparam logic [15:0] AMR_VEC_TMM0     = 16'h000E;
  localparam logic [15:0] AMR_VEC_TMM1     = 16'h0010;
  localparam logic [15:0] AMR_VEC_ADC      = 16'h0012;

  // Table-call area, 64 bytes of subroutine entry addresses.
  localparam logic [15:0] AMR_TCALL_LO     = 16'h0040;
  localparam logic [15:0] AMR_TCALL_HI     = 16'h007F;
  // Option byte and flash protection byte.
  localparam logic [15:0] AMR_OPT_ADDR     = 16'h0080;
  localparam logic [15:0] AMR_PROT_ADDR    = 16'h0081;

  // Fast RAM and peripheral register windows.
  localparam logic [15:0] AMR_RAM_LO       = 16'hFE80;
  localparam logic [15:0] AMR_RAM_HI       = 16'hFEFF;
  localparam logic [15:0] AMR_SFR_LO       = 16'hFF00;
  localparam logic [15:0] AMR_SFR_HI       = 16'hFFFF;
  // Short-address bases: short operands index from these.
  localparam logic [15:0] AMR_RAM_SHORT    = 16'hFE00;
  localparam logic [15:0] AMR_SFR_SHORT    = 16'hFF00;

  // Allowed flash sizes in bytes.
  localparam int AMR_FLASH_1K = 1024;
  localparam int AMR_FLASH_2K = 2048;
  localparam int AMR_FLASH_4K = 4096;

  // Number of byte reads that make up the reset vector fetch.
  localparam int AMR_VEC_BYTES = 2;

  // Undefined-read filler for unmapped space.
  localparam logic [7:0] AMR_UNMAPPED_DATA = 8'hFF;

  // Region select codes reported to the memory side.
  typedef enum logic [2:0]
  {
    AMR_REG_NONE  = 3'b000,
    AMR_REG_FLASH = 3'b001,
    AMR_REG_RAM   = 3'b010,
    AMR_REG_SFR   = 3'b011,
    AMR_REG_OPT   = 3'b100,
    AMR_REG_PROT  = 3'b101
  } amr_region_t;

  // Addressing forms for data accesses.
  typedef enum logic [1:0]
  {
    AMR_AM_FULL   = 2'b00,
    AMR_AM_SADDR  = 2'b01,
    AMR_AM_SFR    = 2'b10
  } amr_amode_t;

  // Program counter update kinds.
  typedef enum logic [1:0]
  {
    AMR_PC_HOLD   = 2'b00,
    AMR_PC_SEQ    = 2'b01,
    AMR_PC_IMM    = 2'b10,
    AMR_PC_REG    = 2'b11
  } amr_pcop_t;

  // Sequencer states.
  typedef enum logic [2:0]
  {
    AMR_ST_RESET  = 3'b000,
    AMR_ST_VLO    = 3'b001,
    AMR_ST_VHI    = 3'b010,
    AMR_ST_RUN    = 3'b011,
    AMR_ST_IVLO   = 3'b100,
    AMR_ST_IVHI   = 3'b101,
    AMR_ST_TLO    = 3'b110,
    AMR_ST_THI    = 3'b111
  } amr_state_t;

endpackage

// ==== verification/amr_mem_model.sv ====
/*
  Behavioural model of the on-chip flash, fast RAM and register window.
  Assumes the decoder's registered addresses and strobes, one clock.
*/
`timescale 1ns/100ps
module amr_mem_model
  import amr_pkg::*;
#(
  parameter int FLASH_BYTES = AMR_FLASH_2K
)
(
  // Clock.
  input  wire logic        clk_i,
  // Flash byte read port.
  input  wire logic [15:0] flash_addr_i,
  input  wire logic        flash_rd_i,
  output logic      [7:0]  flash_rdata_o,
  // Decoded data port.
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [2:0]  mem_region_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o
);
  // Both arrays start cleared so an early read compares a known value.
  logic [7:0] ram_q [0:127] = '{default: 8'h00}; // Fast RAM, stack.
  logic [7:0] sfr_q [0:255] = '{default: 8'h00}; // Register window.
  logic       tog_q = 1'b0;  // Flips each cycle to scramble idle data.

  // One byte per address, so even and odd halves differ.
  function automatic logic [7:0] flash_byte(input logic [15:0] a);
    return a[7:0] ^ {a[10:8], 5'h15};
  endfunction

  // Flash answers within the cycle; idle data alternates between 3CH and C3H.
  always_comb
  begin
    if (flash_rd_i && int'(flash_addr_i) < FLASH_BYTES)
      flash_rdata_o = flash_byte(flash_addr_i);
    else
      flash_rdata_o = {8{tog_q}} ^ 8'h3C;
  end

  // Read data for the decoded access of this cycle.
  always_comb
  begin
    if (mem_rd_i && mem_region_i == AMR_REG_RAM)
      mem_rdata_o = ram_q[mem_addr_i[6:0]];
    else if (mem_rd_i && mem_region_i == AMR_REG_SFR)
      mem_rdata_o = sfr_q[mem_addr_i[7:0]];
    else if (mem_rd_i)
      mem_rdata_o = flash_byte(mem_addr_i);
    else
      mem_rdata_o = {8{~tog_q}} ^ 8'hC3;
  end

  // Writes land on the strobe edge.
  always @(posedge clk_i)
  begin
    tog_q <= ~tog_q;
    if (mem_wr_i && mem_region_i == AMR_REG_RAM)
      ram_q[mem_addr_i[6:0]] <= mem_wdata_i;
    if (mem_wr_i && mem_region_i == AMR_REG_SFR)
      sfr_q[mem_addr_i[7:0]] <= mem_wdata_i;
  end
endmodule

// ==== verification/test_cpu_address_map_reset_vector.sv ====
/*
  Self-checking bench for the address decoder and program counter.
  Assumes the memory model answers flash and data reads in-cycle.
*/
`timescale 1ns/100ps
module test_cpu_address_map_reset_vector;
  import amr_pkg::*;
  // Smaller flash variant, so 0800H must decode as unmapped.
  localparam int FB = AMR_FLASH_2K;
  logic        clk, nrst, tc_req, irq_req, dreq, dwr;
  logic        frd, mrd, mwr, run, vload;
  logic [1:0]  pc_op, pc_len, dmode;
  logic [2:0]  irq_src, mreg;
  logic [4:0]  tc_idx;
  logic [7:0]  dwdata, frdata, mrdata, mwdata, drdata, off;
  logic [15:0] pc_tgt, daddr, faddr, maddr, pc;
  // Shadows of what was written; cleared like the model's arrays.
  logic [7:0]  sh_ram [0:127] = '{default: 8'h00};
  logic [7:0]  sh_sfr [0:255] = '{default: 8'h00};
  int          err_total = 0;
  int          cmp_count = 0;
  logic [15:0] atab [16] = '{16'h0000, 16'h0013, 16'h0014, 16'h003F,
    16'h0040, 16'h007F, 16'h0080, 16'h0081, 16'h0082, 16'h07FF,
    16'h0800, 16'hFE7F, 16'hFE80, 16'hFEFF, 16'hFF00, 16'hFFFF};

  amr_core #(.FLASH_BYTES(FB)) uut (.CLK_I(clk), .NRST_I(nrst),
    .PC_OP_I(pc_op), .PC_LEN_I(pc_len), .PC_TARGET_I(pc_tgt),
    .TCALL_REQ_I(tc_req), .TCALL_IDX_I(tc_idx), .IRQ_REQ_I(irq_req),
    .IRQ_SRC_I(irq_src), .DACC_REQ_I(dreq), .DACC_WR_I(dwr),
    .DACC_MODE_I(dmode), .DACC_ADDR_I(daddr), .DACC_WDATA_I(dwdata),
    .FLASH_RDATA_I(frdata), .FLASH_ADDR_O(faddr), .FLASH_RD_O(frd),
    .MEM_RDATA_I(mrdata), .MEM_ADDR_O(maddr), .MEM_REGION_O(mreg),
    .MEM_RD_O(mrd), .MEM_WR_O(mwr), .MEM_WDATA_O(mwdata),
    .DACC_RDATA_O(drdata), .PC_O(pc), .RUN_O(run), .VEC_LOADED_O(vload));

  amr_mem_model #(.FLASH_BYTES(FB)) mem (.clk_i(clk),
    .flash_addr_i(faddr), .flash_rd_i(frd), .flash_rdata_o(frdata),
    .mem_addr_i(maddr), .mem_region_i(mreg), .mem_rd_i(mrd),
    .mem_wr_i(mwr), .mem_wdata_i(mwdata), .mem_rdata_o(mrdata));

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and count; four-state equality keeps unknowns visible.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Drives change a fixed 1 ns after each rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Expected flash content, worked out independently of the model.
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return a[7:0] ^ {a[10:8], 5'h15};
  endfunction

  function automatic logic [2:0] region_of(input logic [15:0] a);
    if (a == 16'h0080) return AMR_REG_OPT;
    if (a == 16'h0081) return AMR_REG_PROT;
    if (int'(a) < FB) return AMR_REG_FLASH;
    if (a >= 16'hFF00) return AMR_REG_SFR;
    if (a >= 16'hFE80) return AMR_REG_RAM;
    return AMR_REG_NONE;
  endfunction

  // Two-byte entry fetch after the taking edge, low byte first.
  task automatic vec_walk(input logic [15:0] slot);
    tick();
    irq_req = 1'b0;
    tc_req = 1'b0;
    chk(16'(run), 16'h0000);
    chk(faddr, slot);
    chk(16'(frd), 16'h0001);
    tick();
    chk(faddr, slot + 16'h0001);
    tick();
    chk(pc, {exp_byte(slot + 16'h0001), exp_byte(slot)});
    chk(16'(run), 16'h0001);
    chk(16'(vload), 16'h0001);
  endtask

  task automatic pc_step(input logic [1:0] op, input logic [1:0] len,
                         input logic [15:0] tgt);
    logic [15:0] e;
    e = (op == 2'd1) ? pc + 16'(len) : (op[1] ? tgt : pc);
    pc_op = op;
    pc_len = len;
    pc_tgt = tgt;
    tick();
    chk(pc, e);
  endtask

  // One data access; short forms index from the window bases.
  task automatic dacc(input logic wr, input logic [1:0] md,
                      input logic [15:0] a, input logic [7:0] wd);
    logic [15:0] ea;
    logic [2:0]  er;
    ea = (md == 2'd1) ? {8'hFE, a[7:0]} :
         (md == 2'd2) ? {8'hFF, a[7:0]} : a;
    er = region_of(ea);
    dreq = 1'b1;
    dwr = wr;
    dmode = md;
    daddr = a;
    dwdata = wd;
    tick();
    dreq = 1'b0;
    chk(16'(mrd), 16'(!wr && er != 3'd0));
    chk(16'(mwr), 16'(wr && er != 3'd0));
    if (er != 3'd0)
    begin
      chk(16'(mreg), 16'(er));
      chk(maddr, ea);
    end
    if (wr && er == AMR_REG_RAM)
      sh_ram[ea[6:0]] = wd;
    if (wr && er == AMR_REG_SFR)
      sh_sfr[ea[7:0]] = wd;
    if (wr && er != 3'd0)
      chk(16'(mwdata), 16'(wd));
    tick();
    if (!wr && er == AMR_REG_NONE)
      chk(16'(drdata), 16'h00FF);
    if (!wr && er == AMR_REG_RAM)
      chk(16'(drdata), 16'(sh_ram[ea[6:0]]));
    if (!wr && er == AMR_REG_SFR)
      chk(16'(drdata), 16'(sh_sfr[ea[7:0]]));
  endtask

  // Reset, release and the reset-vector walk.
  task automatic do_reset(input int n);
    nrst = 1'b0;
    repeat (n) tick();
    chk(pc, 16'h0000);
    chk(16'(run), 16'h0000);
    chk(16'(frd), 16'h0000);
    chk(16'(vload), 16'h0000);
    nrst = 1'b1;
    vec_walk(16'h0000);
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial
  begin
    #400000;
    err_total++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(16));
    {nrst, pc_op, pc_len, pc_tgt, tc_req, tc_idx} = '0;
    {irq_req, irq_src, dreq, dwr, dmode, daddr, dwdata} = '0;
    do_reset(20);
    // Wrap of the 16-bit counter, then random steps and branches.
    pc_step(2'd2, 2'd1, 16'hFFFF);
    pc_step(2'd1, 2'd3, 16'h0000);
    pc_step(2'd0, 2'd2, 16'h1234);
    repeat (40) pc_step(2'($urandom), 2'($urandom_range(3, 1)),
                        16'($urandom));
    // Every slot; a step held meanwhile must be ignored.
    for (int s = 0; s < 8; s++)
    begin
      irq_src = 3'(s);
      irq_req = 1'b1;
      tc_req = (s == 7);
      pc_op = 2'd1;
      pc_len = 2'd3;
      vec_walk((s == 0) ? 16'h0000 : 16'(4 + 2 * s));
    end
    pc_op = 2'd0;
    // Table-call entries at both ends and in between.
    for (int i = 0; i < 6; i++)
    begin
      tc_idx = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : 5'($urandom);
      tc_req = 1'b1;
      vec_walk(16'h0040 + 16'(2 * tc_idx));
    end
    // Region decode over every boundary of the map.
    foreach (atab[k]) dacc(1'b0, 2'd0, atab[k], 8'h00);
    dacc(1'b1, 2'd0, 16'h0800, 8'h77);
    dacc(1'b1, 2'd1, 16'h0010, 8'h55);
    // Random RAM and register traffic, full and short forms.
    repeat (30)
    begin
      automatic logic s = 1'($urandom);
      automatic logic [1:0] md = 1'($urandom) ? (s ? 2'd2 : 2'd1) : 2'd0;
      automatic logic [15:0] ad;
      automatic logic [7:0]  wd = 8'($urandom);
      // Locals keep the bus pins to one assignment per time step.
      off = 8'($urandom) | (s ? 8'h00 : 8'h80);
      ad = (md == 2'd0) ? {(s ? 8'hFF : 8'hFE), off} : {8'h00, off};
      dacc(1'b1, md, ad, wd);
      dacc(1'b0, md, ad, 8'h00);
    end
    do_reset(2);
    print_verdict();
  end
endmodule
